// file: hdl/rtcai_params.svh
// Purpose: constants of the rtc alarm and update interrupt block
// Assumes: included by bare name
// Notes:   register offsets are word indices, byte address = 4 * index
`ifndef RTCAI_PARAMS_SVH
`define RTCAI_PARAMS_SVH

// --------------------------------------------------
// register indices
// --------------------------------------------------
`define RTCAI_IDX_ALM_MIN  4'h8
`define RTCAI_IDX_ALM_HOUR 4'h9
`define RTCAI_IDX_ALM_DAY  4'hA
`define RTCAI_IDX_EXT      4'hD
`define RTCAI_IDX_FLAG     4'hE
`define RTCAI_IDX_CTRL     4'hF

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define RTCAI_ALM_IGN  7
`define RTCAI_EXT_UPDATE_PERIOD_SELECT 5
`define RTCAI_EXT_WEEKDAY_OR_DATE_SELECT 3
`define RTCAI_FLG_UF   5
`define RTCAI_FLG_TF   4
`define RTCAI_FLG_AF   3
`define RTCAI_CTL_UIE  5
`define RTCAI_CTL_TIE  4
`define RTCAI_CTL_AIE  3
`define RTCAI_CTL_STOP 1

// --------------------------------------------------
// masks and reset values
// --------------------------------------------------
`define RTCAI_FLG_KEEP_MASK 8'hC4
`define RTCAI_CTL_MASK      8'h3E
`define RTCAI_RST_BYTE      8'h00
`define RTCAI_HSIZE_WORD    3'h2

// --------------------------------------------------
// timing
// --------------------------------------------------
`define RTCAI_CLK_NS      10.0
`define RTCAI_UPD_REL_MS  7.813
`define RTCAI_UPD_MAX_MS  23.44
`define RTCAI_ALM_MAX_MS  1.46
`define RTCAI_UPD_REL_CYC ($floor(`RTCAI_UPD_REL_MS * 1.0E6 / `RTCAI_CLK_NS))

`endif

// file: hdl/rtcai_pkg.sv
// Purpose: types of the rtc alarm and update interrupt block
// Assumes: nothing
// Notes:   no constants here, see rtcai_params.svh
package rtcai_pkg;

   // --------------------------------------------------
   // timekeeping view
   // --------------------------------------------------
   typedef struct packed {
      logic       sec_tick;
      logic       min_tick;
      logic [6:0] minute;
      logic [5:0] hour;
      logic [6:0] wday;
      logic [5:0] date;
   } rtcai_time_s;

   // --------------------------------------------------
   // bus slave states
   // --------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WR,
      BUS_RD,
      BUS_RDONE
   } rtcai_bus_e;

endpackage

// file: hdl/rtcai_top.sv
// Purpose: alarm and time-update interrupt logic of a real-time clock
// Assumes: time_i ticks are one-cycle pulses, fields valid with them
// Notes:   ahb-lite slave, word access only, open-drain irq pin
`timescale 1ns/100ps
`include "rtcai_params.svh"

// Summary of operation
// - alarm match sets sticky alarm flag
// - zero write clears alarm flag, releases pin
// - writing one to flags does nothing
// - enabled alarm event pulls pin low
// - disabled alarm never pulls, clearing releases
// - alarm enable gates pin, flag stays
// - weekday mode: any selected weekday bit
// - date mode: bcd day of month compare
// - ignore bit drops field from compare
// - period select: second or minute update
// - update low releases after 7.813ms
// - update low within 23.44ms of update
// - halt blocks update events
// - update detection runs, enable gates pin
// - update event sets sticky update flag
// - zero write clears update flag, releases
// - update enable drives or cancels low
// - alarm flag and pin within 1.46ms
// - halt blocks alarm events
// - alarm fires only on counter advance
// - one pin shared by three sources
module rtcai_top #(
   parameter int unsigned UPD_REL_CYC = int'(`RTCAI_UPD_REL_CYC)
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // ahb-lite slave
   input  wire logic               hsel_i,
   input  wire logic [31:0]        haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [31:0]        hwdata_i,
   input  wire logic               hready_i,
   output logic      [31:0]        hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   // timekeeping and timer events
   input  wire rtcai_pkg::rtcai_time_s time_i,
   input  wire logic               timer_evt_i,
   // interrupt pin, open-drain
   output logic                    irq_o,
   output logic                    irq_oe_o
);

   // --------------------------------------------------
   // declarations
   // --------------------------------------------------
   rtcai_pkg::rtcai_bus_e bus_q;
   logic [3:0]  idx_q;
   logic        addr_ok_q;
   logic        hready_q;
   logic [31:0] hrdata_q;
   logic        hresp_q;
   logic [7:0]  alm_min_q;
   logic [7:0]  alm_hour_q;
   logic [7:0]  alm_day_q;
   logic [7:0]  ext_q;
   logic [7:0]  flg_keep_q;
   logic [7:0]  ctl_q;
   logic        af_q;
   logic        uf_q;
   logic        tf_q;
   logic        uf_req_q;
   logic [19:0] rel_cnt_q;
   logic        irq_oe_q;
   logic        irq_q;
   logic        acc;
   logic        wr_en;
   logic [7:0]  wd;
   logic        wr_flag;
   logic        halted;
   logic        upd_evt;
   logic        alm_evt;
   logic        min_hit;
   logic        hour_hit;
   logic        day_hit;
   logic [7:0]  rd_byte;

   // --------------------------------------------------
   // ahb-lite slave
   // --------------------------------------------------
   assign acc   = hsel_i & htrans_i[1] & hready_i;
   assign wr_en = (bus_q == rtcai_pkg::BUS_WR) & addr_ok_q;
   assign wd    = hwdata_i[7:0];

   // reads take one wait state so a write just before is seen
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_q     <= rtcai_pkg::BUS_IDLE;
         hready_q  <= 1'b1;
         idx_q     <= 4'h0;
         addr_ok_q <= 1'b0;
      end else begin
         case (bus_q)
            rtcai_pkg::BUS_RD: begin
               bus_q    <= rtcai_pkg::BUS_RDONE;
               hready_q <= 1'b1;
            end
            default: begin
               if (acc) begin
                  idx_q     <= haddr_i[5:2];
                  addr_ok_q <= (haddr_i[31:6] == 26'h0) & (haddr_i[1:0] == 2'h0) &
                               (hsize_i == `RTCAI_HSIZE_WORD);
                  if (hwrite_i) begin
                     bus_q <= rtcai_pkg::BUS_WR;
                  end else begin
                     bus_q    <= rtcai_pkg::BUS_RD;
                     hready_q <= 1'b0;
                  end
               end else begin
                  bus_q <= rtcai_pkg::BUS_IDLE;
               end
            end
         endcase
      end
   end

   // unmapped or non-word reads return zero
   always_comb begin
      rd_byte = 8'h00;
      if (!addr_ok_q) begin
         rd_byte = 8'h00;
      end else if (idx_q == `RTCAI_IDX_ALM_MIN) begin
         rd_byte = alm_min_q;
      end else if (idx_q == `RTCAI_IDX_ALM_HOUR) begin
         rd_byte = alm_hour_q;
      end else if (idx_q == `RTCAI_IDX_ALM_DAY) begin
         rd_byte = alm_day_q;
      end else if (idx_q == `RTCAI_IDX_EXT) begin
         rd_byte = ext_q;
      end else if (idx_q == `RTCAI_IDX_FLAG) begin
         rd_byte = flg_keep_q;
         rd_byte[`RTCAI_FLG_UF] = uf_q;
         rd_byte[`RTCAI_FLG_TF] = tf_q;
         rd_byte[`RTCAI_FLG_AF] = af_q;
      end else if (idx_q == `RTCAI_IDX_CTRL) begin
         rd_byte = ctl_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_q <= 32'h0000_0000;
         hresp_q  <= 1'b0;
      end else if (bus_q == rtcai_pkg::BUS_RD) begin
         hrdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // --------------------------------------------------
   // software registers
   // --------------------------------------------------
   // synchronous register writes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alm_min_q  <= `RTCAI_RST_BYTE;
         alm_hour_q <= `RTCAI_RST_BYTE;
         alm_day_q  <= `RTCAI_RST_BYTE;
         ext_q      <= `RTCAI_RST_BYTE;
         flg_keep_q <= `RTCAI_RST_BYTE;
         ctl_q      <= `RTCAI_RST_BYTE;
      end else if (wr_en) begin
         if (idx_q == `RTCAI_IDX_ALM_MIN) begin
            alm_min_q <= wd;
         end else if (idx_q == `RTCAI_IDX_ALM_HOUR) begin
            alm_hour_q <= wd;
         end else if (idx_q == `RTCAI_IDX_ALM_DAY) begin
            alm_day_q <= wd;
         end else if (idx_q == `RTCAI_IDX_EXT) begin
            ext_q <= wd;
         end else if (idx_q == `RTCAI_IDX_FLAG) begin
            flg_keep_q <= wd & `RTCAI_FLG_KEEP_MASK;
         end else if (idx_q == `RTCAI_IDX_CTRL) begin
            ctl_q <= wd & `RTCAI_CTL_MASK;
         end
      end
   end

   assign wr_flag = wr_en & (idx_q == `RTCAI_IDX_FLAG);

   // --------------------------------------------------
   // event detection
   // --------------------------------------------------
   // halt blocks update and alarm events, not timer events
   assign halted = ctl_q[`RTCAI_CTL_STOP];

   assign upd_evt = ~halted & (ext_q[`RTCAI_EXT_UPDATE_PERIOD_SELECT] ? time_i.min_tick : time_i.sec_tick);

   assign min_hit  = alm_min_q[`RTCAI_ALM_IGN] | (alm_min_q[6:0] == time_i.minute);
   assign hour_hit = alm_hour_q[`RTCAI_ALM_IGN] | (alm_hour_q[5:0] == time_i.hour);

   always_comb begin
      day_hit = 1'b1;
      if (alm_day_q[`RTCAI_ALM_IGN]) begin
         day_hit = 1'b1;
      end else if (ext_q[`RTCAI_EXT_WEEKDAY_OR_DATE_SELECT]) begin
         day_hit = (alm_day_q[5:0] == time_i.date);
      end else begin
         day_hit = |(alm_day_q[6:0] & time_i.wday);
      end
   end

   assign alm_evt = ~halted & time_i.min_tick & min_hit & hour_hit & day_hit;

   // --------------------------------------------------
   // sticky flags
   // --------------------------------------------------
   // alarm flag, set wins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         af_q <= 1'b0;
      end else if (alm_evt) begin
         af_q <= 1'b1;
      end else if (wr_flag & ~wd[`RTCAI_FLG_AF]) begin
         af_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uf_q <= 1'b0;
      end else if (upd_evt) begin
         uf_q <= 1'b1;
      end else if (wr_flag & ~wd[`RTCAI_FLG_UF]) begin
         uf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tf_q <= 1'b0;
      end else if (timer_evt_i) begin
         tf_q <= 1'b1;
      end else if (wr_flag & ~wd[`RTCAI_FLG_TF]) begin
         tf_q <= 1'b0;
      end
   end

   // --------------------------------------------------
   // update pulse timing
   // --------------------------------------------------
   // self-releasing update request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uf_req_q  <= 1'b0;
         rel_cnt_q <= 20'h0_0000;
      end else if (upd_evt & ctl_q[`RTCAI_CTL_UIE]) begin
         uf_req_q  <= 1'b1;
         rel_cnt_q <= 20'(UPD_REL_CYC - 1);
      end else if (~ctl_q[`RTCAI_CTL_UIE] | (wr_flag & ~wd[`RTCAI_FLG_UF]) |
                   (rel_cnt_q == 20'h0_0000)) begin
         uf_req_q  <= 1'b0;
      end else begin
         rel_cnt_q <= rel_cnt_q - 20'h0_0001;
      end
   end

   // --------------------------------------------------
   // interrupt pin
   // --------------------------------------------------
   // gated open-drain drive
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_oe_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         irq_oe_q <= (af_q & ctl_q[`RTCAI_CTL_AIE]) | uf_req_q |
                     (tf_q & ctl_q[`RTCAI_CTL_TIE]);
         irq_q    <= 1'b0;
      end
   end

   // --------------------------------------------------
   // outputs
   // --------------------------------------------------
   assign hrdata_o    = hrdata_q;
   assign hreadyout_o = hready_q;
   assign hresp_o     = hresp_q;
   assign irq_o       = irq_q;
   assign irq_oe_o    = irq_oe_q;

endmodule // rtcai_top

// file: tb/rtcai_host_model.sv
// Purpose: host side of the open-drain interrupt pin
// Assumes: pull-up on the board
// Notes:   host reads the flags to find the source
`timescale 1ns/100ps
module rtcai_host_model (
   // pin enable from the device
   input  wire logic irq_oe_i,
   // pin level seen by the host
   output wire logic irq_n_o
);
   assign irq_n_o = irq_oe_i ? 1'b0 : 1'b1;
endmodule // rtcai_host_model

// file: tb/rtcai_top_properties.sv
// Purpose: port properties of the rtc interrupt block
// Assumes: one clock, async active-low reset
// Notes:   register state is not visible here
`timescale 1ns/100ps
module rtcai_top_properties #(
   parameter int unsigned UPD_REL_CYC = 1
) (
   // clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [2:0]  hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   // events and pin
   input wire rtcai_pkg::rtcai_time_s time_i,
   input wire logic        timer_evt_i,
   input wire logic        irq_o,
   input wire logic        irq_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic tk;
   logic wph_q;
   assign tk = hsel_i && htrans_i[1] && hready_i;
   // write data phase, a later cause of the pin
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) wph_q <= 1'b0;
      else wph_q <= tk && hwrite_i;
   end
   a_irq_data_low: assert property (irq_o == 1'b0) else $error("irq data not low");
   a_resp_okay: assert property (hresp_o == 1'b0) else $error("response not okay");
   a_read_wait: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait");
   a_write_nowait: assert property (tk && hwrite_i |=> hreadyout_o) else $error("write waited");
   a_fell_cause: assert property ($fell(hreadyout_o) |-> $past(tk && !hwrite_i)) else $error("stray wait");
   a_rdata_upper: assert property (hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
   a_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
      else $error("read data moved");
   a_oe_cause: assert property ($rose(irq_oe_o) |-> $past(time_i.sec_tick || time_i.min_tick || timer_evt_i
      || wph_q, 2) || $past(wph_q, 1) || $past(wph_q, 3)) else $error("pin pulled without cause");
endmodule // rtcai_top_properties

bind rtcai_top rtcai_top_properties #(.UPD_REL_CYC(UPD_REL_CYC)) props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .time_i(time_i), .timer_evt_i(timer_evt_i), .irq_o(irq_o), .irq_oe_o(irq_oe_o));

// file: tb/rtcai_top_test.sv
// Purpose: self-checking bench of the rtc interrupt block
// Assumes: release count shortened to keep the run short
// Notes:   timer event input pulsed once to show the shared pin
`timescale 1ns/100ps
`include "rtcai_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module rtcai_top_test;
   localparam int unsigned REL = 20;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0;
   logic        tev = 1'b0;
   logic        hready, hresp, irq, irq_oe, pin_n;
   rtcai_pkg::rtcai_time_s tm = '0;
   int n_errors = 0;
   int samples_checked = 0;
   always #5 clk_i = ~clk_i;
   rtcai_top #(.UPD_REL_CYC(REL)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(`RTCAI_HSIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .time_i(tm),
      .timer_evt_i(tev), .irq_o(irq), .irq_oe_o(irq_oe));
   rtcai_host_model host (.irq_oe_i(irq_oe), .irq_n_o(pin_n));
   // --------------------------------------------------
   // bus and event tasks
   // --------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      haddr <= {26'h0, a, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(rd, {24'h0, e}) // read path
   endtask
   task automatic pin(input logic e);
      repeat (3) @(posedge clk_i);
      `CHK(pin_n, e) // pin level
   endtask
   // tick lasts one cycle, fields stay
   task automatic tk(input logic s, m, input logic [6:0] mi, wd, input logic [5:0] dt);
      tm <= '{s, m, mi, 6'h00, wd, dt};
      @(posedge clk_i);
      tm.sec_tick <= 1'b0;
      tm.min_tick <= 1'b0;
   endtask
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   task automatic t_regs;
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      rdc(4'h3, 8'h00);
      bus(1'b1, `RTCAI_IDX_EXT, 8'hA5);
      rdc(`RTCAI_IDX_EXT, 8'hA5);
      $display("regs done");
   endtask
   task automatic t_update;
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h00);
      bus(1'b1, `RTCAI_IDX_EXT, 8'h00);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h20);
      tk(1'b1, 1'b0, 7'h00, 7'h01, 6'h01);
      pin(1'b0);
      rdc(`RTCAI_IDX_FLAG, 8'h20);
      repeat (REL - 10) @(posedge clk_i);
      `CHK(pin_n, 1'b0)
      repeat (10) @(posedge clk_i);
      `CHK(pin_n, 1'b1)
      bus(1'b1, `RTCAI_IDX_FLAG, 8'hFF);
      rdc(`RTCAI_IDX_FLAG, 8'hE4);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      bus(1'b1, `RTCAI_IDX_EXT, 8'h20);
      tk(1'b1, 1'b0, 7'h00, 7'h01, 6'h01);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      tk(1'b0, 1'b1, 7'h01, 7'h01, 6'h01);
      pin(1'b0);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      pin(1'b1);
      tk(1'b0, 1'b1, 7'h02, 7'h01, 6'h01);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h00);
      pin(1'b1);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      tk(1'b0, 1'b1, 7'h03, 7'h01, 6'h01);
      pin(1'b1);
      rdc(`RTCAI_IDX_FLAG, 8'h20);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h22);
      tk(1'b1, 1'b1, 7'h03, 7'h01, 6'h01);
      pin(1'b1);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h00);
      bus(1'b1, `RTCAI_IDX_EXT, 8'h00);
      $display("update done");
   endtask
   task automatic t_alarm;
      tk(1'b0, 1'b0, 7'h30, 7'h40, 6'h15);
      bus(1'b1, `RTCAI_IDX_ALM_MIN, 8'h30);
      bus(1'b1, `RTCAI_IDX_ALM_HOUR, 8'h80);
      bus(1'b1, `RTCAI_IDX_ALM_DAY, 8'h41);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h08);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      tk(1'b0, 1'b1, 7'h30, 7'h02, 6'h15);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      tk(1'b0, 1'b1, 7'h30, 7'h40, 6'h15);
      pin(1'b0);
      rdc(`RTCAI_IDX_FLAG, 8'h08);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h00);
      pin(1'b1);
      rdc(`RTCAI_IDX_FLAG, 8'h08);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h08);
      pin(1'b0);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      pin(1'b1);
      bus(1'b1, `RTCAI_IDX_EXT, 8'h08);
      bus(1'b1, `RTCAI_IDX_ALM_DAY, 8'h15);
      tk(1'b0, 1'b1, 7'h30, 7'h40, 6'h14);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      bus(1'b1, `RTCAI_IDX_ALM_MIN, 8'h80);
      tk(1'b0, 1'b1, 7'h11, 7'h40, 6'h15);
      rdc(`RTCAI_IDX_FLAG, 8'h08);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h0A);
      tk(1'b0, 1'b1, 7'h12, 7'h40, 6'h15);
      rdc(`RTCAI_IDX_FLAG, 8'h00);
      $display("alarm done");
   endtask
   task automatic t_timer;
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h10);
      tev <= 1'b1;
      @(posedge clk_i);
      tev <= 1'b0;
      pin(1'b0);
      rdc(`RTCAI_IDX_FLAG, 8'h10);
      bus(1'b1, `RTCAI_IDX_FLAG, 8'h00);
      pin(1'b1);
      bus(1'b1, `RTCAI_IDX_CTRL, 8'h00);
      $display("timer done");
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a hang costs one mismatch, the run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_regs;
      t_update;
      t_alarm;
      t_timer;
      finish_test;
   end
endmodule // rtcai_top_test
